// File: hdl/mtseq_pkg.sv
// shared constants and types for the message transmit sequencer
package mtseq_pkg;
	// wishbone byte addresses
	localparam logic [3:0] MTSEQ_ADDR_CTRL = 4'h0;
	localparam logic [3:0] MTSEQ_ADDR_STATUS = 4'h4;
	localparam logic [3:0] MTSEQ_ADDR_DEST = 4'h8;
	// control register fields
	localparam int MTSEQ_CTRL_SEND = 0;
	localparam int MTSEQ_CTRL_ABORT = 1;
	localparam int MTSEQ_CTRL_CLRST = 2;
	localparam int MTSEQ_CTRL_PATHB = 3;
	localparam int MTSEQ_CTRL_LOOP = 4;
	// status register fields
	localparam int MTSEQ_ST_PARITY = 7;
	localparam int MTSEQ_ST_CARR_A = 6;
	localparam int MTSEQ_ST_CARR_B = 5;
	localparam int MTSEQ_ST_ABORT = 4;
	localparam int MTSEQ_ST_ARBZ = 3;
	localparam int MTSEQ_ST_NACK = 2;
	localparam int MTSEQ_ST_ACK = 1;
	localparam int MTSEQ_ST_BUSY = 0;
	localparam int MTSEQ_ST_ATTN = 8;
	localparam int MTSEQ_ST_ACTIVE = 9;
	localparam int MTSEQ_ST_WAIT = 10;
	// reset values
	localparam logic [7:0] MTSEQ_STATUS_RST = 8'h00;
	localparam logic [7:0] MTSEQ_DEST_RST = 8'h00;
	// framing table
	localparam logic [7:0] MTSEQ_BITSYNC_BYTE = 8'h55;
	localparam logic [7:0] MTSEQ_SYNC_CHAR = 8'h96;
	localparam logic [7:0] MTSEQ_TRAILER_BYTE = 8'h55;
	localparam logic [7:0] MTSEQ_BITSYNC_N = 8'h04;
	localparam logic [7:0] MTSEQ_TRAILER_N = 8'h04;
	localparam logic [7:0] MTSEQ_CRC_LAST = 8'h03;
	// timing
	localparam int MTSEQ_CLK_MHZ = 250;
	localparam logic [7:0] MTSEQ_BYTE_CYCLES = 8'h08;
	localparam int MTSEQ_RESPONSE_TIMEOUT_NS = 3660;
	localparam int MTSEQ_RESPONSE_TIMEOUT_CYC = (MTSEQ_RESPONSE_TIMEOUT_NS * MTSEQ_CLK_MHZ) / 1000;
	localparam logic [11:0] MTSEQ_RESPONSE_TIMEOUT_MAX = 12'(MTSEQ_RESPONSE_TIMEOUT_CYC);
	// first and second sequencer states
	typedef enum logic [2:0] {MX_A, MX_B, MX_C, MX_D, MX_E, MX_F} mtseq_mx1_e;
	typedef enum logic [2:0] {MX_G, MX_H, MX_I, MX_J, MX_K, MX_L, MX_M} mtseq_mx2_e;
	// stored control fields
	typedef struct packed {
		logic loop;
		logic path_b;
	} mtseq_ctrl_s;
endpackage

// File: hdl/mtseq_top.sv
// message transmit sequencer with wishbone register port
// Function
// - initialization pulses tx init, resets logic, first sequencer idle A
// - send command in idle sets active flag and enters arbitration B
// - B waits for arbitration won, then goes to C
// - C sends bit sync bytes and sync char, then D on counter done
// - D enables CRC unless looping, starts second sequencer, goes E
// - first sequencer holds in E; parity fault sends it to F
// - F resets second sequencer, raises attention, returns to A
// - second sequencer G to H on D, then I latches destination byte
// - J sends body; drained goes to K, or L when looping
// - K sends CRC bytes, last one moves to L
// - L sends trailer bytes, counter done moves to M
// - M raises wait flag; receiver clear or final ends transfer
// - abort command sets status 4, two flops later resets sequencers
// - header timeout from receiver resets the transmit sequence
// - preamble gate drives sync/trailer bytes; packet gate disables it
// - bus connect passes body, isolates during CRC, reconnects in L
// - message drives selected path from C until trailer done
// - response transmit drives last receive path from start until done
// - attention on ack, nack, timeout, parity fault in E or abort
// - status 7 parity fault; 6 and 5 show carrier A and B
// - status 3 arbitration countdown zero; 0 busy or attention
// - status 2 on nack, 1 on ack, each raising attention
// - M starts response timer; 3.66 us expiry signals timeout
// - states without hold condition last exactly one clock
`timescale 1ns/100ps
module mtseq_top import mtseq_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// arbiter and receive logic
	input wire logic bus_grant_won_i,
	input wire logic arb_count_zero_i,
	input wire logic header_timeout_i,
	input wire logic response_rx_clear_i,
	input wire logic response_rx_final_i,
	input wire logic response_done_i,
	input wire logic nack_rcvd_i,
	input wire logic parity_fault_i,
	// response transmitter
	input wire logic response_tx_start_i,
	input wire logic response_tx_done_i,
	input wire logic last_rx_path_i,
	// cable carrier pins
	input wire logic carrier_a_i,
	input wire logic carrier_b_i,
	// packet buffer and crc generator
	input wire logic [7:0] pkt_byte_i,
	input wire logic tx_buffer_drained_i,
	input wire logic [7:0] crc_byte_i,
	output logic pkt_take_o,
	output logic crc_take_o,
	output logic crc_enable_o,
	// transmit data path
	output logic [7:0] tx_byte_bus_o,
	output logic tx_byte_strobe_o,
	output logic tx_parity_o,
	output logic preamble_gate_o,
	output logic packet_byte_gate_o,
	output logic tx_bus_connect_o,
	output logic path_a_drive_o,
	output logic path_b_drive_o,
	// sequence state
	output logic tx_init_pulse_o,
	output logic tx_active_flag_o,
	output logic awaiting_response_o,
	output logic response_timeout_o,
	output logic tx_attention_o,
	output logic [7:0] tx_status_bits_o
);

	mtseq_mx1_e mx1_reg;
	mtseq_mx2_e mx2_reg;
	mtseq_ctrl_s ctrl_reg;
	logic wb_req;
	logic wr_ctrl;
	logic send_command;
	logic abort_send_command;
	logic clr_status;
	logic abort_s1_reg;
	logic tx_abort_pulse;
	logic seq_kill;
	logic response_done;
	logic [7:0] div_reg;
	logic byte_tick;
	logic [7:0] cnt_reg;
	logic preamble_tail_done;
	logic [11:0] to_cnt_reg;
	logic ca_s1_reg;
	logic ca_s2_reg;
	logic cb_s1_reg;
	logic cb_s2_reg;
	logic [7:0] dest_reg;
	logic [7:0] sticky_reg;
	logic attn_reg;
	logic attn_set;
	logic msg_drive_reg;
	logic msg_path_b_reg;
	logic rsp_drive_reg;
	logic rsp_path_b_reg;
	logic [7:0] status_full;

	// bus decode, one wait state keeps read data registered
	assign wb_req = cyc_i & stb_i & ~ack_o;
	assign wr_ctrl = wb_req & we_i & sel_i[0] & (adr_i == MTSEQ_ADDR_CTRL);
	assign send_command = wr_ctrl & dat_i[MTSEQ_CTRL_SEND];
	assign abort_send_command = wr_ctrl & dat_i[MTSEQ_CTRL_ABORT];
	assign clr_status = wr_ctrl & dat_i[MTSEQ_CTRL_CLRST];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (wb_req & ~we_i) begin
			unique case (adr_i)
				MTSEQ_ADDR_CTRL: begin
					dat_o <= {27'h0, ctrl_reg.loop, ctrl_reg.path_b, 3'h0};
				end
				MTSEQ_ADDR_STATUS: begin
					dat_o <= {21'h0, awaiting_response_o, tx_active_flag_o,
						attn_reg, status_full};
				end
				MTSEQ_ADDR_DEST: begin
					dat_o <= {24'h0, dest_reg};
				end
				default: begin
					dat_o <= 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= '0;
		end else if (wr_ctrl) begin
			ctrl_reg.path_b <= dat_i[MTSEQ_CTRL_PATHB];
			ctrl_reg.loop <= dat_i[MTSEQ_CTRL_LOOP];
		end
	end

	always_ff @(posedge clk_i) begin
		tx_init_pulse_o <= rst_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_s1_reg <= 1'b0;
			tx_abort_pulse <= 1'b0;
		end else begin
			abort_s1_reg <= abort_send_command;
			tx_abort_pulse <= abort_s1_reg;
		end
	end

	assign seq_kill = tx_abort_pulse | header_timeout_i;
	assign response_done = response_rx_clear_i | response_rx_final_i;

	// carrier pins are asynchronous
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ca_s1_reg <= 1'b0;
			ca_s2_reg <= 1'b0;
			cb_s1_reg <= 1'b0;
			cb_s2_reg <= 1'b0;
		end else begin
			ca_s1_reg <= carrier_a_i;
			ca_s2_reg <= ca_s1_reg;
			cb_s1_reg <= carrier_b_i;
			cb_s2_reg <= cb_s1_reg;
		end
	end

	// byte rate divider, free running
	assign byte_tick = (div_reg == MTSEQ_BYTE_CYCLES - 8'h01);
	always_ff @(posedge clk_i) begin
		if (rst_i || byte_tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// first sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill) begin
			mx1_reg <= MX_A;
		end else begin
			unique case (mx1_reg)
				MX_A: begin
					if (send_command) begin
						mx1_reg <= MX_B;
					end
				end
				MX_B: begin
					if (bus_grant_won_i) begin
						mx1_reg <= MX_C;
					end
				end
				MX_C: begin
					if (preamble_tail_done) begin
						mx1_reg <= MX_D;
					end
				end
				MX_D: begin
					mx1_reg <= MX_E;
				end
				MX_E: begin
					if (parity_fault_i) begin
						mx1_reg <= MX_F;
					end else if (mx2_reg == MX_M && response_done) begin
						mx1_reg <= MX_A;
					end else if (to_cnt_reg == MTSEQ_RESPONSE_TIMEOUT_MAX) begin
						mx1_reg <= MX_A;
					end
				end
				MX_F: begin
					mx1_reg <= MX_A;
				end
			endcase
		end
	end

	// second sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill || mx1_reg == MX_F) begin
			mx2_reg <= MX_G;
		end else begin
			unique case (mx2_reg)
				MX_G: begin
					if (mx1_reg == MX_D) begin
						mx2_reg <= MX_H;
					end
				end
				MX_H: begin
					mx2_reg <= MX_I;
				end
				MX_I: begin
					mx2_reg <= MX_J;
				end
				MX_J: begin
					if (byte_tick && tx_buffer_drained_i) begin
						mx2_reg <= ctrl_reg.loop ? MX_L : MX_K;
					end
				end
				MX_K: begin
					if (byte_tick && cnt_reg == MTSEQ_CRC_LAST) begin
						mx2_reg <= MX_L;
					end
				end
				MX_L: begin
					if (preamble_tail_done) begin
						mx2_reg <= MX_M;
					end
				end
				MX_M: begin
					if (response_done || to_cnt_reg == MTSEQ_RESPONSE_TIMEOUT_MAX) begin
						mx2_reg <= MX_G;
					end
				end
			endcase
		end
	end

	// sync/trailer and crc byte counter
	assign preamble_tail_done = byte_tick &&
		((mx1_reg == MX_C && cnt_reg == MTSEQ_BITSYNC_N) ||
		(mx2_reg == MX_L && cnt_reg == MTSEQ_TRAILER_N - 8'h01));
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill) begin
			cnt_reg <= 8'h00;
		end else if (preamble_tail_done) begin
			cnt_reg <= 8'h00;
		end else if (mx2_reg == MX_J || mx2_reg == MX_G && mx1_reg != MX_C) begin
			cnt_reg <= 8'h00;
		end else if (mx2_reg == MX_K && byte_tick && cnt_reg == MTSEQ_CRC_LAST) begin
			cnt_reg <= 8'h00;
		end else if (byte_tick) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// byte bus, one byte per divider tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_byte_bus_o <= 8'h00;
			tx_byte_strobe_o <= 1'b0;
		end else begin
			tx_byte_strobe_o <= 1'b0;
			if (byte_tick) begin
				if (mx1_reg == MX_C) begin
					tx_byte_bus_o <= (cnt_reg == MTSEQ_BITSYNC_N) ?
						MTSEQ_SYNC_CHAR : MTSEQ_BITSYNC_BYTE;
					tx_byte_strobe_o <= 1'b1;
				end else if (mx2_reg == MX_J && !tx_buffer_drained_i) begin
					tx_byte_bus_o <= pkt_byte_i;
					tx_byte_strobe_o <= 1'b1;
				end else if (mx2_reg == MX_K) begin
					tx_byte_bus_o <= crc_byte_i;
					tx_byte_strobe_o <= 1'b1;
				end else if (mx2_reg == MX_L) begin
					tx_byte_bus_o <= MTSEQ_TRAILER_BYTE;
					tx_byte_strobe_o <= 1'b1;
				end
			end
		end
	end

	assign pkt_take_o = byte_tick & (mx2_reg == MX_J) & ~tx_buffer_drained_i;
	assign crc_take_o = byte_tick & (mx2_reg == MX_K);

	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill) begin
			preamble_gate_o <= 1'b0;
			packet_byte_gate_o <= 1'b0;
		end else begin
			packet_byte_gate_o <= (mx2_reg == MX_J);
			preamble_gate_o <= (mx2_reg != MX_J) &&
				(mx1_reg == MX_C || mx2_reg == MX_L);
		end
	end
	assign tx_parity_o = packet_byte_gate_o & ~(^tx_byte_bus_o);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_bus_connect_o <= 1'b1;
		end else if (mx2_reg == MX_L) begin
			tx_bus_connect_o <= 1'b1;
		end else if (mx2_reg == MX_J && tx_buffer_drained_i) begin
			tx_bus_connect_o <= 1'b0;
		end
	end

	// crc enable in D unless looping, held until trailer state L
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill || mx2_reg == MX_L || mx2_reg == MX_G && mx1_reg != MX_D) begin
			crc_enable_o <= 1'b0;
		end else if (mx1_reg == MX_D && !ctrl_reg.loop) begin
			crc_enable_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_reg <= MTSEQ_DEST_RST;
		end else if (mx2_reg == MX_I) begin
			dest_reg <= pkt_byte_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill || mx1_reg == MX_F) begin
			tx_active_flag_o <= 1'b0;
		end else if (mx1_reg == MX_A && send_command) begin
			tx_active_flag_o <= 1'b1;
		end else if (mx2_reg == MX_M && response_done) begin
			tx_active_flag_o <= 1'b0;
		end else if (mx2_reg == MX_M && to_cnt_reg == MTSEQ_RESPONSE_TIMEOUT_MAX) begin
			tx_active_flag_o <= 1'b0;
		end
	end

	assign awaiting_response_o = (mx2_reg == MX_M);

	always_ff @(posedge clk_i) begin
		if (rst_i || mx2_reg != MX_M) begin
			to_cnt_reg <= 12'h000;
		end else if (to_cnt_reg != MTSEQ_RESPONSE_TIMEOUT_MAX) begin
			to_cnt_reg <= to_cnt_reg + 12'h001;
		end
	end
	assign response_timeout_o = (mx2_reg == MX_M) & (to_cnt_reg == MTSEQ_RESPONSE_TIMEOUT_MAX) &
		~response_done;

	always_ff @(posedge clk_i) begin
		if (rst_i || seq_kill || mx1_reg == MX_F) begin
			msg_drive_reg <= 1'b0;
			msg_path_b_reg <= 1'b0;
		end else if (mx1_reg == MX_B && bus_grant_won_i) begin
			msg_drive_reg <= 1'b1;
			msg_path_b_reg <= ctrl_reg.path_b;
		end else if (mx2_reg == MX_L && preamble_tail_done) begin
			msg_drive_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_drive_reg <= 1'b0;
			rsp_path_b_reg <= 1'b0;
		end else if (response_tx_start_i) begin
			rsp_drive_reg <= 1'b1;
			rsp_path_b_reg <= last_rx_path_i;
		end else if (response_tx_done_i) begin
			rsp_drive_reg <= 1'b0;
		end
	end
	assign path_a_drive_o = (msg_drive_reg & ~msg_path_b_reg) |
		(rsp_drive_reg & ~rsp_path_b_reg);
	assign path_b_drive_o = (msg_drive_reg & msg_path_b_reg) |
		(rsp_drive_reg & rsp_path_b_reg);

	assign attn_set = response_done_i | nack_rcvd_i | response_timeout_o |
		(mx1_reg == MX_F) | abort_send_command;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			attn_reg <= 1'b0;
		end else if (attn_set) begin
			attn_reg <= 1'b1;
		end else if (clr_status) begin
			attn_reg <= 1'b0;
		end
	end
	assign tx_attention_o = attn_reg;

	// sticky status, set wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sticky_reg <= MTSEQ_STATUS_RST;
		end else begin
			if (parity_fault_i && tx_active_flag_o) begin
				sticky_reg[MTSEQ_ST_PARITY] <= 1'b1;
			end else if (clr_status) begin
				sticky_reg[MTSEQ_ST_PARITY] <= 1'b0;
			end
			if (abort_send_command) begin
				sticky_reg[MTSEQ_ST_ABORT] <= 1'b1;
			end else if (clr_status) begin
				sticky_reg[MTSEQ_ST_ABORT] <= 1'b0;
			end
			if (arb_count_zero_i) begin
				sticky_reg[MTSEQ_ST_ARBZ] <= 1'b1;
			end else if (clr_status) begin
				sticky_reg[MTSEQ_ST_ARBZ] <= 1'b0;
			end
			if (nack_rcvd_i) begin
				sticky_reg[MTSEQ_ST_NACK] <= 1'b1;
			end else if (clr_status) begin
				sticky_reg[MTSEQ_ST_NACK] <= 1'b0;
			end
			if (response_done_i) begin
				sticky_reg[MTSEQ_ST_ACK] <= 1'b1;
			end else if (clr_status) begin
				sticky_reg[MTSEQ_ST_ACK] <= 1'b0;
			end
		end
	end

	always_comb begin
		status_full = sticky_reg;
		status_full[MTSEQ_ST_CARR_A] = ca_s2_reg;
		status_full[MTSEQ_ST_CARR_B] = cb_s2_reg;
		status_full[MTSEQ_ST_BUSY] = tx_active_flag_o | attn_reg;
	end
	assign tx_status_bits_o = status_full;

endmodule

// File: testbench/mtseq_asserts.sv
// assertion checker for the message transmit sequencer
`timescale 1ns/100ps
module mtseq_asserts import mtseq_pkg::*; (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// events
	input wire logic header_timeout_i,
	input wire logic response_rx_clear_i,
	input wire logic response_rx_final_i,
	input wire logic response_done_i,
	input wire logic nack_rcvd_i,
	input wire logic arb_count_zero_i,
	input wire logic carrier_a_i,
	// watched outputs
	input wire logic preamble_gate_o,
	input wire logic packet_byte_gate_o,
	input wire logic tx_parity_o,
	input wire logic tx_init_pulse_o,
	input wire logic tx_active_flag_o,
	input wire logic awaiting_response_o,
	input wire logic response_timeout_o,
	input wire logic tx_attention_o,
	input wire logic [7:0] tx_status_bits_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic abort_wr;
	logic [11:0] m_cnt;
	assign abort_wr = cyc_i && stb_i && we_i && !ack_o && adr_i == MTSEQ_ADDR_CTRL && sel_i[0]
		&& dat_i[MTSEQ_CTRL_ABORT];
	// counts cycles spent waiting, bounded check beats an eventuality
	always_ff @(posedge clk_i) begin
		if (rst_i || !awaiting_response_o) begin
			m_cnt <= 12'h000;
		end else begin
			m_cnt <= m_cnt + 12'h001;
		end
	end
	AST_INIT: assert property (disable iff (1'b0) rst_i |=> tx_init_pulse_o)
		else $error("init pulse missing");
	AST_BUS_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus ack missing");
	AST_RESP_END: assert property (awaiting_response_o && (response_rx_clear_i ||
		response_rx_final_i) |=> !tx_active_flag_o && !awaiting_response_o)
		else $error("sequence not ended by response");
	AST_WAIT_ACTIVE: assert property ($rose(awaiting_response_o) |-> tx_active_flag_o)
		else $error("wait flag without active");
	AST_ABORT: assert property (abort_wr |-> ##[1:2] (tx_status_bits_o[MTSEQ_ST_ABORT]
		&& tx_attention_o) ##[1:3] !tx_active_flag_o)
		else $error("abort not honoured");
	AST_HDR_TO: assert property (header_timeout_i |-> ##[1:2] !tx_active_flag_o)
		else $error("header timeout ignored");
	AST_GATES: assert property (!(preamble_gate_o && packet_byte_gate_o))
		else $error("both byte gates on");
	AST_PARITY: assert property (!packet_byte_gate_o |-> !tx_parity_o)
		else $error("parity without packet gate");
	AST_CARR_A: assert property (carrier_a_i [*5] |-> tx_status_bits_o[MTSEQ_ST_CARR_A])
		else $error("carrier a not shown");
	AST_BUSY: assert property ((tx_active_flag_o || tx_attention_o) [*2] |->
		tx_status_bits_o[MTSEQ_ST_BUSY]) else $error("busy bit clear");
	AST_ARBZ: assert property (arb_count_zero_i |-> ##[1:2] tx_status_bits_o[MTSEQ_ST_ARBZ])
		else $error("arb zero bit not set");
	AST_ACK_RX: assert property (response_done_i |-> ##[1:2] (tx_status_bits_o[MTSEQ_ST_ACK] &&
		tx_attention_o)) else $error("ack not flagged");
	AST_NACK_RX: assert property (nack_rcvd_i |-> ##[1:2] (tx_status_bits_o[MTSEQ_ST_NACK] &&
		tx_attention_o)) else $error("nack not flagged");
	AST_RESP_TIMER: assert property (awaiting_response_o |-> m_cnt <= 12'h394)
		else $error("response wait too long");
	AST_RESP_TO: assert property (response_timeout_o |-> awaiting_response_o ##1
		!awaiting_response_o) else $error("timeout did not end wait");
endmodule
bind mtseq_top mtseq_asserts i_mtseq_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
	.sel_i, .dat_i, .ack_o, .header_timeout_i, .response_rx_clear_i, .response_rx_final_i,
	.response_done_i, .nack_rcvd_i, .arb_count_zero_i, .carrier_a_i, .preamble_gate_o,
	.packet_byte_gate_o, .tx_parity_o, .tx_init_pulse_o, .tx_active_flag_o,
	.awaiting_response_o, .response_timeout_o, .tx_attention_o, .tx_status_bits_o);

// File: testbench/mtseq_pbuf_model.sv
// packet buffer and crc source model
`timescale 1ns/100ps
module mtseq_pbuf_model (
	// clock, reset, load
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [7:0] count_i,
	// pops
	input wire logic take_i,
	input wire logic crc_take_i,
	// data
	output logic [7:0] byte_o,
	output logic drained_o,
	output logic [7:0] crc_o
);
	logic [7:0] idx_reg;
	logic [7:0] cidx_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i || load_i) begin
			idx_reg <= 8'h00;
			cidx_reg <= 8'h00;
		end else begin
			if (take_i && idx_reg < count_i) idx_reg <= idx_reg + 8'h01;
			if (crc_take_i) cidx_reg <= cidx_reg + 8'h01;
		end
	end
	assign drained_o = idx_reg >= count_i;
	// released bus shows the inverse of its last byte, never a stale match
	assign byte_o = drained_o ? ~(8'h9f + idx_reg) : 8'ha0 + idx_reg;
	assign crc_o = 8'hc0 + cidx_reg;
endmodule

// File: testbench/tb_mtseq_top.sv
// self-checking testbench for the message transmit sequencer
`timescale 1ns/100ps
module tb_mtseq_top import mtseq_pkg::*;;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, grant = 0, arbz = 0, hto = 0;
	logic rclr = 0, rfin = 0, ackr = 0, nackr = 0, pfault = 0, rtx_s = 0, rtx_d = 0, lastb = 0;
	logic car_a = 0, car_b = 0, pb_load = 0, crc_seen, drained, pkt_take, crc_take, crc_en;
	logic strobe, init_p, active, waiting, rto, attn, drv_a, drv_b, conn;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [7:0] pb_n = 8'h00, pkt_byte, crc_byte, bus, st;
	logic [7:0] got_q[$], exp_q[$];
	int err_count = 0, n_compared = 0, cyc_n = 0, wcount;
	always #2 clk_i = ~clk_i;
	mtseq_top i_mtseq_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.bus_grant_won_i(grant), .arb_count_zero_i(arbz), .header_timeout_i(hto),
		.response_rx_clear_i(rclr), .response_rx_final_i(rfin), .response_done_i(ackr),
		.nack_rcvd_i(nackr), .parity_fault_i(pfault), .response_tx_start_i(rtx_s),
		.response_tx_done_i(rtx_d), .last_rx_path_i(lastb), .carrier_a_i(car_a),
		.carrier_b_i(car_b), .pkt_byte_i(pkt_byte), .tx_buffer_drained_i(drained),
		.crc_byte_i(crc_byte), .pkt_take_o(pkt_take), .crc_take_o(crc_take),
		.crc_enable_o(crc_en), .tx_byte_bus_o(bus), .tx_byte_strobe_o(strobe), .tx_parity_o(),
		.preamble_gate_o(), .packet_byte_gate_o(), .tx_bus_connect_o(conn),
		.path_a_drive_o(drv_a), .path_b_drive_o(drv_b), .tx_init_pulse_o(init_p),
		.tx_active_flag_o(active), .awaiting_response_o(waiting), .response_timeout_o(rto),
		.tx_attention_o(attn), .tx_status_bits_o(st));
	mtseq_pbuf_model i_mtseq_pbuf_model (.clk_i(clk_i), .rst_i(rst_i), .load_i(pb_load),
		.count_i(pb_n), .take_i(pkt_take), .crc_take_i(crc_take), .byte_o(pkt_byte),
		.drained_o(drained), .crc_o(crc_byte));
	task final_report;
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// hang guard, whole run needs well under this
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_count++;
			final_report;
		end
	end
	always @(posedge clk_i) begin
		if (strobe === 1'b1) begin
			if (got_q.size() == 5) crc_seen <= crc_en;
			got_q.push_back(bus);
		end
	end
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (k >= 50) chk("ack", 1, 0);
	endtask
	localparam int EV_LOAD = 0, EV_FIN = 1, EV_ACK = 2, EV_CLR = 3, EV_NACK = 4;
	localparam int EV_PF = 5, EV_HTO = 6, EV_ARBZ = 7, EV_RTXS = 8, EV_RTXD = 9;
	// event lines picked by number, nonblocking writes through a reference are not portable
	task automatic ev(input int s, input logic v);
		case (s)
			EV_LOAD: pb_load <= v;
			EV_FIN: rfin <= v;
			EV_ACK: ackr <= v;
			EV_CLR: rclr <= v;
			EV_NACK: nackr <= v;
			EV_PF: pfault <= v;
			EV_HTO: hto <= v;
			EV_ARBZ: arbz <= v;
			EV_RTXS: rtx_s <= v;
			default: rtx_d <= v;
		endcase
	endtask
	task automatic pulse(input int s);
		@(posedge clk_i);
		ev(s, 1'b1);
		@(posedge clk_i);
		ev(s, 1'b0);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: sig = drv_a | drv_b;
			1: sig = waiting;
			2: sig = rto;
			default: sig = crc_en;
		endcase
	endfunction
	task automatic wt(input int s);
		wcount = 0;
		while (sig(s) !== 1'b1 && wcount < 3000) begin
			@(posedge clk_i);
			wcount++;
		end
		if (wcount >= 3000) chk("wait", 1, 0);
	endtask
	task automatic clr;
		wb(1'b1, MTSEQ_ADDR_CTRL, 32'h4);
		wb(1'b0, MTSEQ_ADDR_STATUS, 32'h0);
		chk("clear", 0, q[7:0]);
	endtask
	task automatic start(input logic [7:0] ctl, input logic [7:0] n);
		pb_n <= n;
		pulse(EV_LOAD);
		got_q.delete();
		wb(1'b1, MTSEQ_ADDR_CTRL, {24'h0, ctl | 8'h01});
		repeat (2) @(posedge clk_i);
		chk("active", 1, active);
		repeat (3) @(posedge clk_i);
		chk("no_grant", 0, drv_a | drv_b);
		grant <= 1'b1;
		wt(0);
		grant <= 1'b0;
		chk("path_b", ctl[3], drv_b);
	endtask
	task automatic msg(input logic [7:0] ctl, input logic [7:0] n);
		start(ctl, n);
		wt(1);
		// last trailer strobe is queued on the edge that shows the wait flag
		@(posedge clk_i);
		exp_q.delete();
		for (int i = 0; i < MTSEQ_BITSYNC_N; i++) exp_q.push_back(MTSEQ_BITSYNC_BYTE);
		exp_q.push_back(MTSEQ_SYNC_CHAR);
		for (int i = 0; i < n; i++) exp_q.push_back(8'ha0 + 8'(i));
		if (!ctl[4]) for (int i = 0; i <= MTSEQ_CRC_LAST; i++) exp_q.push_back(8'hc0 + 8'(i));
		for (int i = 0; i < MTSEQ_TRAILER_N; i++) exp_q.push_back(MTSEQ_TRAILER_BYTE);
		chk("count", exp_q.size(), got_q.size());
		foreach (exp_q[i]) chk("byte", exp_q[i], got_q[i]);
		chk("crc_en", !ctl[4], crc_seen);
		chk("drive_off", 0, drv_a | drv_b);
		chk("active_m", 1, active);
		wb(1'b0, MTSEQ_ADDR_DEST, 32'h0);
		chk("dest", 8'ha0, q[7:0]);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		chk("init", 1, init_p);
		chk("connect", 1, conn);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("init_low", 0, init_p);
		wb(1'b0, MTSEQ_ADDR_STATUS, 32'h0);
		chk("status_rst", 0, q);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 0, q);
		msg(8'h00, 8'd3);
		pulse(EV_FIN);
		repeat (2) @(posedge clk_i);
		chk("idle_fin", 0, active | waiting);
		pulse(EV_ACK);
		wb(1'b0, MTSEQ_ADDR_STATUS, 32'h0);
		chk("ack_st", 32'h103, q);
		clr();
		msg(8'h18, 8'd2);
		pulse(EV_CLR);
		repeat (2) @(posedge clk_i);
		chk("idle_clr", 0, active | waiting);
		wb(1'b0, MTSEQ_ADDR_CTRL, 32'h0);
		chk("ctrl_rb", 32'h18, q);
		pulse(EV_NACK);
		repeat (2) @(posedge clk_i);
		chk("nack", 2'b11, {st[MTSEQ_ST_NACK], attn});
		clr();
		msg(8'h00, 8'd1);
		wt(2);
		chk("to_time", 1, wcount >= 910 && wcount <= 920);
		repeat (2) @(posedge clk_i);
		chk("to_end", 2'b01, {active, attn});
		clr();
		start(8'h00, 8'd4);
		wb(1'b1, MTSEQ_ADDR_CTRL, 32'h2);
		repeat (3) @(posedge clk_i);
		chk("abort", 2'b11, {st[MTSEQ_ST_ABORT], attn});
		chk("abort_idle", 0, active | drv_a | drv_b);
		clr();
		start(8'h00, 8'd4);
		wt(3);
		pulse(EV_PF);
		repeat (2) @(posedge clk_i);
		chk("parity", 2'b11, {st[MTSEQ_ST_PARITY], attn});
		wb(1'b1, MTSEQ_ADDR_CTRL, 32'h2);
		clr();
		start(8'h00, 8'd4);
		pulse(EV_HTO);
		repeat (2) @(posedge clk_i);
		chk("hdr_to", 0, active);
		clr();
		car_a <= 1'b1;
		pulse(EV_ARBZ);
		repeat (4) @(posedge clk_i);
		chk("carrier_a", 8'h48, st);
		car_a <= 1'b0;
		car_b <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk("carrier_b", 8'h28, st);
		lastb <= 1'b1;
		pulse(EV_RTXS);
		repeat (2) @(posedge clk_i);
		chk("rtx_b", 2'b10, {drv_b, drv_a});
		pulse(EV_RTXD);
		repeat (2) @(posedge clk_i);
		chk("rtx_off", 0, drv_b);
		lastb <= 1'b0;
		pulse(EV_RTXS);
		repeat (2) @(posedge clk_i);
		chk("rtx_a", 2'b01, {drv_b, drv_a});
		final_report;
	end
endmodule
